// [core/lbm_mapper.sv]
// Purpose: Steers the low 32K CPU window to boot EPROM or a banked RAM
// Assumes: CPU strobes are synchronous to MCLK; one clock domain
// Notes: Select and bank held in a control register reached over Wishbone
//   The fitted RAM size comes from a strap pin and is synchronised first
//   Chip selects and RAM pins are registered: selects trail the CPU bus by one cycle, pins trail the bank latch by one cycle
//   Writes in the low window always reach RAM, so software can fill it from EPROM
//   A 128K part with bank bit 2 set is left disabled; software must avoid it
//   An unused strap code is treated as the smallest part
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
module lbm_mapper
(
    input wire logic MCLK,
    input wire logic SRST,
    // Wishbone classic slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    // Answer side, registered; ack and err are pulses
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    // Fitted RAM size strap
    input wire logic [1:0] RAM_SIZE,
    // CPU memory bus
    input wire logic [15:0] CPU_ADDR,
    input wire logic CPU_MREQ,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    // Chip selects and banked address lines
    output logic EPROM_CS,
    output logic EXP_RAM_CS,
    output logic BOARD_RAM_CS,
    output logic RAM_ADDR_LINE_FIFTEEN,
    output logic RAM_ADDR_LINE_SIXTEEN,
    output logic RAM_ADDR_LINE_SEVENTEEN,
    output logic RAM_ADDR_LINE_EIGHTEEN,
    output logic RAM_SECOND_CHIP_ENABLE
);
    // Control latch: read-source select and bank number
    logic ram_sel_reg;
    logic ram_sel_next;
    logic [3:0] bank_reg;
    logic [3:0] bank_next;

    // Bus answer: ack and err held for one cycle, read data until the next taken request
    logic ack_reg;
    logic ack_next;
    logic err_reg;
    logic err_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Two-stage strap synchroniser
    logic [1:0] size_meta_reg;
    logic [1:0] size_meta_next;
    logic [1:0] size_sync_reg;
    logic [1:0] size_sync_next;

    // Registered chip selects
    logic eprom_cs_reg;
    logic eprom_cs_next;
    logic exp_cs_reg;
    logic exp_cs_next;
    logic board_cs_reg;
    logic board_cs_next;

    // Registered RAM pins: second enable on top, then lines eighteen down to fifteen
    logic [4:0] pins_reg;
    logic [4:0] pins_next;

    // Decode helpers
    logic req;
    logic hit_ctrl;
    logic hit_status;
    logic [3:0] bank_inv;
    logic low_window;

    // A request is taken only while no answer stands, so one strobe gives one answer
    assign req = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
    // Only the two register offsets answer with ack
    assign hit_ctrl = (WB_ADR_I == lbm_pkg::CTRL_OFFSET);
    assign hit_status = (WB_ADR_I == lbm_pkg::STATUS_OFFSET);

    // Bus decode; answer one cycle after the request, error on unmapped
    always_comb
    begin
        ram_sel_next = ram_sel_reg;
        bank_next = bank_reg;
        ack_next = 1'b0;
        err_next = 1'b0;
        rdata_next = rdata_reg;
        if (req)
        begin
            // Unmapped offsets get an error answer, read as zero and leave the control latch unchanged
            if (hit_ctrl || hit_status)
            begin
                ack_next = 1'b1;
            end
            else
            begin
                err_next = 1'b1;
            end
            // Control bits sit in byte lane 0; other lanes are ignored
            if (hit_ctrl && WB_WE_I && WB_SEL_I[0])
            begin
                ram_sel_next = WB_DAT_I[lbm_pkg::RAM_SEL_POS];
                bank_next = WB_DAT_I[lbm_pkg::BANK_LSB_POS +: 4];
            end
            // Read data is rebuilt for every taken request
            rdata_next = 32'h0000_0000;
            if (hit_ctrl)
            begin
                rdata_next[lbm_pkg::RAM_SEL_POS] = ram_sel_reg;
                rdata_next[lbm_pkg::BANK_LSB_POS +: 4] = bank_reg;
            end
            else if (hit_status)
            begin
                rdata_next[1:0] = size_sync_reg;
            end
        end
    end

    // Control latch holds until written again or reset
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ram_sel_reg <= lbm_pkg::CTRL_RAM_SEL_RESET;
            bank_reg <= lbm_pkg::CTRL_BANK_RESET;
            // Answer lines are pulses; none may survive a reset
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ram_sel_reg <= ram_sel_next;
            bank_reg <= bank_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
        end
    end

    // Strap comes from a pin, so it passes two flip-flops before use;
    // only the second stage feeds the decode, the first may be metastable
    always_comb
    begin
        size_meta_next = RAM_SIZE;
        size_sync_next = size_meta_reg;
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            size_meta_reg <= 2'h0;
            size_sync_reg <= 2'h0;
        end
        else
        begin
            size_meta_reg <= size_meta_next;
            size_sync_reg <= size_sync_next;
        end
    end

    // Bank bits reach the RAM pins inverted, one gate per bit
    generate
        for (genvar gi = 0; gi < 4; gi++)
        begin : g_bank_inv
            assign bank_inv[gi] = ~bank_reg[gi];
        end
    endgenerate

    // Low window is everything below the 32K boundary
    assign low_window = (CPU_ADDR < lbm_pkg::LOW_WINDOW_LIMIT);

    // Memory decode; registered so pin outputs come from flip-flops
    always_comb
    begin
        eprom_cs_next = 1'b0;
        exp_cs_next = 1'b0;
        board_cs_next = 1'b0;
        // No strobe, no select
        if (CPU_MREQ && (CPU_RD || CPU_WR))
        begin
            // The upper half always belongs to the fixed board RAM
            if (!low_window)
            begin
                board_cs_next = 1'b1;
            end
            else if (CPU_WR)
            begin
                // Writes ignore the select so RAM can be filled while reads come from EPROM
                exp_cs_next = 1'b1;
            end
            else if (ram_sel_reg)
            begin
                exp_cs_next = 1'b1;
            end
            else
            begin
                eprom_cs_next = 1'b1;
            end
        end
    end

    // Chip selects trail the CPU bus by one cycle; the bus has no wait state to hide it
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            eprom_cs_reg <= 1'b0;
            exp_cs_reg <= 1'b0;
            board_cs_reg <= 1'b0;
        end
        else
        begin
            eprom_cs_reg <= eprom_cs_next;
            exp_cs_reg <= exp_cs_next;
            board_cs_reg <= board_cs_next;
        end
    end

    // Pin map per fitted part; unwired lines stay low, an unused enable stays high
    always_comb
    begin
        pins_next = 5'h10;
        case (lbm_pkg::lbm_ram_size_t'(size_sync_reg))
            lbm_pkg::LBM_RAM_32K:
            begin
                // No bank bit is wired, so every bank reaches the same cells
                pins_next[3:0] = 4'h0;
                pins_next[4] = 1'b1;
            end
            lbm_pkg::LBM_RAM_128K:
            begin
                // Bit 2 low gives enable high; banks 4 to 7 and 12 to 15 disable the part
                pins_next[1:0] = bank_inv[1:0];
                pins_next[3:2] = 2'h0;
                pins_next[4] = bank_inv[2];
            end
            lbm_pkg::LBM_RAM_512K:
            begin
                // All four bits wired, so sixteen distinct banks
                pins_next[3:0] = bank_inv;
                pins_next[4] = 1'b1;
            end
            default:
            begin
                // Unused strap code behaves as the smallest part
                pins_next[3:0] = 4'h0;
                pins_next[4] = 1'b1;
            end
        endcase
    end

    // Pins follow the bank latch whether or not the CPU is accessing
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            pins_reg <= 5'h00;
        end
        else
        begin
            pins_reg <= pins_next;
        end
    end

    // Bus answer straight from flip-flops
    assign WB_ACK_O = ack_reg;
    assign WB_ERR_O = err_reg;
    assign WB_DAT_O = rdata_reg;

    // Chip selects
    assign EPROM_CS = eprom_cs_reg;
    assign EXP_RAM_CS = exp_cs_reg;
    assign BOARD_RAM_CS = board_cs_reg;

    // RAM pins, bit order as in pins_next
    assign RAM_ADDR_LINE_FIFTEEN = pins_reg[0];
    assign RAM_ADDR_LINE_SIXTEEN = pins_reg[1];
    assign RAM_ADDR_LINE_SEVENTEEN = pins_reg[2];
    assign RAM_ADDR_LINE_EIGHTEEN = pins_reg[3];
    assign RAM_SECOND_CHIP_ENABLE = pins_reg[4];
endmodule

// [core/lbm_pkg.sv]
// Purpose: Shared constants for the lower memory bank mapper
// Assumes: Wishbone classic register bus, 32-bit data
// Notes: Offsets are byte addresses
package lbm_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int RAM_SEL_POS = 4;
    localparam int BANK_LSB_POS = 0;
    localparam logic CTRL_RAM_SEL_RESET = 1'b0;
    localparam logic [3:0] CTRL_BANK_RESET = 4'h0;
    localparam logic [15:0] LOW_WINDOW_LIMIT = 16'h8000;
    typedef enum logic [1:0]
    {
        LBM_RAM_32K = 2'h0,
        LBM_RAM_128K = 2'h1,
        LBM_RAM_512K = 2'h3
    } lbm_ram_size_t;
endpackage

// [sim/lbm_asserts.sv]
// Purpose: Port-level checks for lbm_mapper
// Assumes: One MCLK domain, SRST sync high
// Notes: Strap must settle 5 cycles before pin checks
`timescale 1ns/1ps
module lbm_asserts
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic WB_ACK_O,
    input wire logic [1:0] RAM_SIZE,
    input wire logic [15:0] CPU_ADDR,
    input wire logic CPU_MREQ,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    input wire logic EPROM_CS,
    input wire logic EXP_RAM_CS,
    input wire logic BOARD_RAM_CS,
    input wire logic RAM_ADDR_LINE_FIFTEEN,
    input wire logic RAM_ADDR_LINE_SIXTEEN,
    input wire logic RAM_ADDR_LINE_SEVENTEEN,
    input wire logic RAM_ADDR_LINE_EIGHTEEN,
    input wire logic RAM_SECOND_CHIP_ENABLE
);
    // Pin bundle and low-window strobe
    wire [4:0] pins = {RAM_ADDR_LINE_EIGHTEEN, RAM_ADDR_LINE_SEVENTEEN, RAM_ADDR_LINE_SIXTEEN,
        RAM_ADDR_LINE_FIFTEEN, RAM_SECOND_CHIP_ENABLE};
    wire low = CPU_MREQ && !CPU_ADDR[15];
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    // Long enough for the strap synchroniser and pin flop
    sequence strap_held(v);
        (!SRST && RAM_SIZE == v) [*5];
    endsequence
    sequence quiet;
        (!WB_ACK_O && $stable(RAM_SIZE)) [*5];
    endsequence
    wr_to_ram_a: assert property (low && CPU_WR |=> EXP_RAM_CS && !EPROM_CS)
        else $error("low write missed ram");
    high_board_a: assert property (CPU_MREQ && CPU_ADDR[15] && (CPU_RD || CPU_WR)
        |=> BOARD_RAM_CS && !EXP_RAM_CS)
        else $error("high access missed board ram");
    rst_rom_a: assert property ($fell(SRST) && low && CPU_RD |=> EPROM_CS)
        else $error("rom not default after reset");
    one_source_a: assert property (low && CPU_RD |=> (EPROM_CS ^ EXP_RAM_CS) && !BOARD_RAM_CS)
        else $error("low read source not unique");
    pin_hold_a: assert property (quiet |-> $stable(pins))
        else $error("pins moved without write");
    small_ram_a: assert property (strap_held(2'h0) |-> pins == 5'h01)
        else $error("small ram pins wrong");
    mid_ram_a: assert property (strap_held(2'h1) |-> pins[4:3] == 2'h0)
        else $error("mid ram upper lines driven");
    ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
endmodule
bind lbm_mapper lbm_asserts i_lbm_asserts(.*);

// [sim/lbm_cpu_model.sv]
// Purpose: Processor bus partner for lbm_mapper
// Assumes: op 0 idle, 1 read, 2 write
// Notes: Idle address flips each cycle so stale values never match
`timescale 1ns/1ps
module lbm_cpu_model
(
    input wire logic clk,
    input wire logic [1:0] op,
    input wire logic [15:0] addr,
    output logic [15:0] cpu_addr,
    output logic cpu_mreq,
    output logic cpu_rd,
    output logic cpu_wr
);
    // One strobe at a time; released bus shows no old address
    always_ff @(posedge clk)
    begin
        cpu_addr <= (op == 2'h0) ? ~cpu_addr : addr;
        cpu_mreq <= op != 2'h0;
        cpu_rd <= op == 2'h1;
        cpu_wr <= op == 2'h2;
    end
endmodule

// [sim/lower_memory_bank_mapper_test.sv]
// Purpose: Self-checking bench for lbm_mapper
// Assumes: 100 MHz MCLK, reset held 4 cycles
// Notes: Row = size, ctrl, expected pins
`timescale 1ns/1ps
module lower_memory_bank_mapper_test;
    logic MCLK = 0, SRST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [3:0] WB_SEL_I = 4'hf;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rdat;
    logic [1:0] RAM_SIZE = 2'h0, op = 2'h1;
    logic [15:0] CPU_ADDR, cad = 16'h1234;
    logic CPU_MREQ, CPU_RD, CPU_WR, WB_ACK_O, WB_ERR_O, EPROM_CS, EXP_RAM_CS, BOARD_RAM_CS, ackd, errd;
    logic RAM_ADDR_LINE_FIFTEEN, RAM_ADDR_LINE_SIXTEEN, RAM_ADDR_LINE_SEVENTEEN, RAM_ADDR_LINE_EIGHTEEN;
    logic RAM_SECOND_CHIP_ENABLE;
    wire [4:0] pins = {RAM_ADDR_LINE_EIGHTEEN, RAM_ADDR_LINE_SEVENTEEN, RAM_ADDR_LINE_SIXTEEN,
        RAM_ADDR_LINE_FIFTEEN, RAM_SECOND_CHIP_ENABLE};
    int fails = 0, tests_run = 0;
    // 128K rows keep bank bit 2 low so the part stays enabled
    logic [11:0] rows [6] = '{12'h2a1, 12'h443, 12'h607, 12'hc1f, 12'hf2d, 12'hde1};
    lbm_mapper i_lbm_mapper(.*);
    lbm_cpu_model i_lbm_cpu_model(.clk(MCLK), .op(op), .addr(cad), .cpu_addr(CPU_ADDR),
        .cpu_mreq(CPU_MREQ), .cpu_rd(CPU_RD), .cpu_wr(CPU_WR));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string name, logic [31:0] seen, logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fails++;
            $display("MISMATCH %s want %h seen %h", name, want, seen);
        end
    endtask
    // Classic cycle, held until ack or err is sampled
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= w;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        do
        begin
            @(posedge MCLK);
            n++;
        end while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1 && n < 20);
        if (n == 20)
        begin
            fails++;
            print_verdict();
        end
        rdat = WB_DAT_O;
        ackd = WB_ACK_O;
        errd = WB_ERR_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge MCLK);
    endtask
    // Selects answer one cycle after the model presents the access
    task automatic cpu(logic [1:0] o, logic [15:0] a);
        op <= o;
        cad <= a;
        repeat (3) @(posedge MCLK);
    endtask
    initial
    begin
        forever #5 MCLK = ~MCLK;
    end
    initial
    begin
        repeat (4) @(posedge MCLK);
        SRST <= 1'b0;
        cpu(2'h1, 16'h1234);
        chk("rom after reset", {31'h0, EPROM_CS}, 32'h1);
        chk("pins after reset", {27'h0, pins}, 32'h1);
        foreach (rows[i])
        begin
            RAM_SIZE <= rows[i][11:10];
            wb(1'b1, lbm_pkg::CTRL_OFFSET, {27'h0, rows[i][9:5]});
            cpu(2'h1, 16'h7fff);
            chk("pins", {27'h0, pins}, {27'h0, rows[i][4:0]});
            chk("ram read", {31'h0, EXP_RAM_CS}, {31'h0, rows[i][9]});
            $display("row %0d done", i);
        end
        wb(1'b1, lbm_pkg::CTRL_OFFSET, 32'h0);
        cpu(2'h2, 16'h0100);
        chk("write with rom", {31'h0, EXP_RAM_CS}, 32'h1);
        cpu(2'h1, 16'h8000);
        chk("high read", {31'h0, BOARD_RAM_CS}, 32'h1);
        wb(1'b1, 8'h08, 32'h1f);
        chk("unmapped", {31'h0, ackd}, 32'h0);
        chk("unmapped err", {31'h0, errd}, 32'h1);
        WB_SEL_I <= 4'he;
        wb(1'b1, lbm_pkg::CTRL_OFFSET, 32'h1f);
        WB_SEL_I <= 4'hf;
        wb(1'b0, lbm_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl held", rdat, 32'h0);
        wb(1'b1, lbm_pkg::CTRL_OFFSET, 32'h1a);
        SRST <= 1'b1;
        repeat (2) @(posedge MCLK);
        SRST <= 1'b0;
        cpu(2'h1, 16'h0010);
        chk("rom after reset again", {31'h0, EPROM_CS}, 32'h1);
        wb(1'b0, lbm_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl after reset", rdat, 32'h0);
        wb(1'b0, lbm_pkg::STATUS_OFFSET, 32'h0);
        chk("strap status", rdat, 32'h3);
        chk("pins after reset again", {27'h0, pins}, 32'h1f);
        $display("hand tests done");
        print_verdict();
    end
endmodule
